// ==== pmc_top.sv ====
`default_nettype none
`include "pmc_consts.svh"
// Functional notes
// R1: Exactly one of five modes: boot, test, firmware, system, user.
// R2: Super-system flag only when in boot, test or firmware.
// R3: Application code never runs in boot, test or firmware.
// R4: Test-disable clear: reset ends in test mode.
// R5: Test-disable set: reset ends in system mode.
// R6: Test-disable is one-way; nothing clears it. Reset clears td_sticky; the fuse level or a new burn sets it again.
// R7: System mode full SFR access; user mode denied unless granted.
// R8: System software grants or denies user access per subset register.
// R9: Firmware access to subset uses system-programmed grants.
// R10: Each exception and interrupt jumps to its own fixed vector. Code ignores both in boot and test mode.
// R11: Eight firmware and 32 system call vectors, entered only by call.
// R12: Firmware vector call enters firmware mode. Code takes the call only from system or user mode.
// R13: System vector call enters system mode. Code takes the call only from user mode.
// R14: Boot and firmware blocked from application memory; test full access.
// R15: Mode register changes only on reset, vector entry, return; exported.
// R16: Denied SFR access: write ignored, read returns zero.
module pmc_top
#(
  parameter int BOOT_CYCLES = `PMC_BOOT_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic test_disable_fuse,
  input wire logic test_disable_burn,
  input wire logic fw_call,
  input wire logic [2:0] fw_call_idx,
  input wire logic sys_call,
  input wire logic [4:0] sys_call_idx,
  input wire logic exc_req,
  input wire logic [2:0] exc_idx,
  input wire logic irq_req,
  input wire logic [3:0] irq_idx,
  input wire logic ret_req,
  input wire logic ret_to_user,
  input wire logic boot_done,
  input wire logic app_mem_req,
  input wire logic sfr_req,
  input wire logic sfr_we,
  input wire logic [`PMC_SFR_AW-1:0] sfr_addr,
  input wire logic [31:0] sfr_wdata,
  input wire logic [31:0] sfr_rdata_in,
  input wire logic grant_we,
  input wire logic grant_sel_fw,
  input wire logic [`PMC_HW_SUBSET_N-1:0] grant_wdata,
  output logic [2:0] mode,
  output logic super_system,
  output logic jump,
  output logic [31:0] jump_addr,
  output logic test_disabled,
  output logic app_mem_allow,
  output logic sfr_fwd_we,
  output logic sfr_fwd_re,
  output logic [`PMC_SFR_AW-1:0] sfr_fwd_addr,
  output logic [31:0] sfr_fwd_wdata,
  output logic [31:0] sfr_rdata,
  output logic sfr_denied
);
  ////////////////////////////////////////////////////////////////////////////
  pmc_pkg::pmc_mode_t cur;
  pmc_pkg::pmc_mode_t next_cur;
  logic [7:0] boot_cnt;
  logic td_sticky;
  logic [`PMC_HW_SUBSET_N-1:0] grant_user;
  logic [`PMC_HW_SUBSET_N-1:0] grant_fw;
  logic [31:0] next_addr;
  logic next_jump;
  pmc_sfr_if sif();

  function automatic logic [31:0] vec(input logic [31:0] base, input logic [4:0] i);
    vec = base + {24'h0000_00, 3'b000, i} * 32'(1 << `PMC_VEC_STRIDE_SH);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // R6: sticky test-disable, fuse level re-sampled after reset
  always_ff @(posedge clk)
  begin
    if (rst)
      td_sticky <= 1'b0;
    else if (test_disable_fuse || test_disable_burn)
      td_sticky <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      boot_cnt <= 8'h00;
    else if (cur == pmc_pkg::PMC_BOOT && boot_cnt != 8'(BOOT_CYCLES))
      boot_cnt <= boot_cnt + 8'h01;
  end

  // R8: grants written only from system mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      grant_user <= `PMC_GRANT_RESET;
      grant_fw <= `PMC_GRANT_RESET;
    end
    else if (grant_we && cur == pmc_pkg::PMC_SYS)
    begin
      if (grant_sel_fw)
        grant_fw <= grant_wdata;
      else
        grant_user <= grant_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R15: mode moves only on boot end, vector or return
  always_comb
  begin
    next_cur = cur;
    next_jump = 1'b0;
    next_addr = jump_addr;
    case (cur)
      pmc_pkg::PMC_BOOT:
      begin
        if (boot_done && boot_cnt == 8'(BOOT_CYCLES))
        begin
          next_jump = 1'b1;
          // R4: test when not disabled
          // R5: system when disabled
          if (td_sticky || test_disable_fuse)
          begin
            next_cur = pmc_pkg::PMC_SYS;
            next_addr = `PMC_SYS_ENTRY;
          end
          else
          begin
            next_cur = pmc_pkg::PMC_TEST;
            next_addr = `PMC_TEST_ENTRY;
          end
        end
      end
      pmc_pkg::PMC_TEST, pmc_pkg::PMC_SYS, pmc_pkg::PMC_USER, pmc_pkg::PMC_FW:
      begin
        // R10: fixed vector per source, priority exc > irq
        if (exc_req && cur != pmc_pkg::PMC_TEST)
        begin
          next_jump = 1'b1;
          next_cur = pmc_pkg::PMC_SYS;
          next_addr = vec(`PMC_EXC_VEC_BASE, {2'b00, exc_idx});
        end
        else if (irq_req && cur != pmc_pkg::PMC_TEST)
        begin
          next_jump = 1'b1;
          next_cur = pmc_pkg::PMC_SYS;
          next_addr = vec(`PMC_IRQ_VEC_BASE, {1'b0, irq_idx});
        end
        // R11: vectors only on explicit call
        // R12: firmware call to firmware
        else if (fw_call && (cur == pmc_pkg::PMC_SYS || cur == pmc_pkg::PMC_USER))
        begin
          next_jump = 1'b1;
          next_cur = pmc_pkg::PMC_FW;
          next_addr = vec(`PMC_FW_VEC_BASE, {2'b00, fw_call_idx});
        end
        // R13: system call to system
        else if (sys_call && cur == pmc_pkg::PMC_USER)
        begin
          next_jump = 1'b1;
          next_cur = pmc_pkg::PMC_SYS;
          next_addr = vec(`PMC_SYS_VEC_BASE, sys_call_idx);
        end
        // R3: returns only land in system or user
        else if (ret_req && cur != pmc_pkg::PMC_TEST)
          next_cur = ret_to_user ? pmc_pkg::PMC_USER : pmc_pkg::PMC_SYS;
      end
      default: next_cur = pmc_pkg::PMC_BOOT;
    endcase
  end

  // R1: single encoded mode register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= pmc_pkg::PMC_BOOT;
      jump <= 1'b0;
      jump_addr <= 32'h0000_0000;
    end
    else
    begin
      cur <= next_cur;
      jump <= next_jump;
      jump_addr <= next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sif.req = sfr_req;
  assign sif.we = sfr_we;
  assign sif.addr = sfr_addr;
  assign sif.mode = cur;
  assign sif.grant_user = grant_user;
  assign sif.grant_fw = grant_fw;

  pmc_sfr_gate u_gate
  (
    .g(sif.gate)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode <= 3'b000;
      super_system <= 1'b1;
      test_disabled <= 1'b0;
      app_mem_allow <= 1'b0;
      sfr_fwd_we <= 1'b0;
      sfr_fwd_re <= 1'b0;
      sfr_fwd_addr <= '0;
      sfr_fwd_wdata <= 32'h0000_0000;
      sfr_rdata <= 32'h0000_0000;
      sfr_denied <= 1'b0;
    end
    else
    begin
      // R15: export current mode
      mode <= cur;
      // R2: super-system from mode only
      super_system <= (cur == pmc_pkg::PMC_BOOT || cur == pmc_pkg::PMC_TEST || cur == pmc_pkg::PMC_FW);
      test_disabled <= td_sticky;
      // R14: boot and firmware blocked
      app_mem_allow <= app_mem_req && (cur == pmc_pkg::PMC_TEST || cur == pmc_pkg::PMC_SYS
                       || cur == pmc_pkg::PMC_USER);
      // R16: denied access blocked
      sfr_fwd_we <= sfr_req && sfr_we && sif.allow;
      sfr_fwd_re <= sfr_req && !sfr_we && sif.allow;
      sfr_fwd_addr <= sfr_addr;
      sfr_fwd_wdata <= sfr_wdata;
      // No read strobe, no data: idle bus content never leaks out
      sfr_rdata <= (sfr_req && !sfr_we && sif.allow) ? sfr_rdata_in : 32'h0000_0000;
      sfr_denied <= sfr_req && !sif.allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_TD_STICKY: assert property (@(posedge clk) disable iff (rst) td_sticky |=> td_sticky) // R6
    else $error("test disable cleared");
  AST_SUPER: assert property (@(posedge clk) disable iff (rst)
    super_system |-> (mode != 3'b011 && mode != 3'b010)) // R2
    else $error("super flag in sys or user");
  AST_FW_CALL: assert property (@(posedge clk) disable iff (rst)
    (fw_call && !exc_req && !irq_req && cur == pmc_pkg::PMC_USER) |=> (cur == pmc_pkg::PMC_FW && jump)) // R12
    else $error("firmware call missed");
  AST_SYS_CALL: assert property (@(posedge clk) disable iff (rst)
    (sys_call && !fw_call && !exc_req && !irq_req && cur == pmc_pkg::PMC_USER)
    |=> (cur == pmc_pkg::PMC_SYS && jump_addr == vec(`PMC_SYS_VEC_BASE, $past(sys_call_idx)))) // R13
    else $error("system call missed");
  AST_BOOT_END: assert property (@(posedge clk) disable iff (rst)
    (cur == pmc_pkg::PMC_BOOT && next_cur != pmc_pkg::PMC_BOOT)
    |=> (cur == (td_sticky ? pmc_pkg::PMC_SYS : pmc_pkg::PMC_TEST) || $past(test_disable_fuse))) // R4
    else $error("bad reset end mode");
  AST_BOOT_SYS: assert property (@(posedge clk) disable iff (rst)
    (cur == pmc_pkg::PMC_TEST) |-> !td_sticky || $past(cur == pmc_pkg::PMC_TEST)) // R5
    else $error("test entered while disabled");
  AST_USER_DENY: assert property (@(posedge clk) disable iff (rst)
    (sfr_req && cur == pmc_pkg::PMC_USER && grant_user == 16'h0000) |=> (sfr_denied && !sfr_fwd_we)) // R7
    else $error("user access leaked");
  AST_FW_MEM: assert property (@(posedge clk) disable iff (rst)
    (cur == pmc_pkg::PMC_FW || cur == pmc_pkg::PMC_BOOT) |=> !app_mem_allow) // R14
    else $error("firmware reached app memory");
  AST_MODE_OUT: assert property (@(posedge clk) disable iff (rst) 1'b1 |=> mode == $past(cur)) // R15
    else $error("mode export lag");
  AST_DENY_READ: assert property (@(posedge clk) disable iff (rst)
    sfr_denied |-> sfr_rdata == 32'h0000_0000) // R16
    else $error("denied read leaked data");

  COV_FW: cover property (@(posedge clk) cur == pmc_pkg::PMC_FW);
  COV_USER_SYS: cover property (@(posedge clk) cur == pmc_pkg::PMC_USER ##1 cur == pmc_pkg::PMC_SYS);
  COV_TEST: cover property (@(posedge clk) cur == pmc_pkg::PMC_TEST);
  COV_DENY: cover property (@(posedge clk) sfr_denied);
endmodule
`default_nettype wire

// ==== pmc_consts.svh ====
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_NUM_FW_VEC 8
`define PMC_NUM_SYS_VEC 32
`define PMC_NUM_EXC 8
`define PMC_NUM_IRQ 16
`define PMC_SFR_AW 8
`define PMC_HW_SUBSET_N 16
`define PMC_FW_VEC_BASE 32'h0000_0100
`define PMC_SYS_VEC_BASE 32'h0000_0200
`define PMC_EXC_VEC_BASE 32'h0000_0400
`define PMC_IRQ_VEC_BASE 32'h0000_0500
`define PMC_TEST_ENTRY 32'h0000_0040
`define PMC_SYS_ENTRY 32'h0000_1000
`define PMC_VEC_STRIDE_SH 3
`define PMC_GRANT_RESET 16'h0000
`define PMC_BOOT_CYCLES 4
`endif

// ==== pmc_pkg.sv ====
`default_nettype none
package pmc_pkg;
  // Gray codes along boot -> test -> system -> user -> firmware
  typedef enum logic [2:0] {
    PMC_BOOT = 3'b000,
    PMC_TEST = 3'b001,
    PMC_SYS = 3'b011,
    PMC_USER = 3'b010,
    PMC_FW = 3'b110
  } pmc_mode_t;
endpackage
`default_nettype wire

// ==== pmc_sfr_if.sv ====
`default_nettype none
`include "pmc_consts.svh"
interface pmc_sfr_if;
  logic req;
  logic we;
  logic [`PMC_SFR_AW-1:0] addr;
  pmc_pkg::pmc_mode_t mode;
  logic [`PMC_HW_SUBSET_N-1:0] grant_user;
  logic [`PMC_HW_SUBSET_N-1:0] grant_fw;
  logic allow;
  modport ctrl (output req, we, addr, mode, grant_user, grant_fw, input allow);
  modport gate (input req, we, addr, mode, grant_user, grant_fw, output allow);
endinterface
`default_nettype wire

// ==== pmc_sfr_gate.sv ====
`default_nettype none
`include "pmc_consts.svh"
module pmc_sfr_gate
(
  pmc_sfr_if.gate g
);
  ////////////////////////////////////////////////////////////////////////////
  // Subset registers sit at the bottom of the SFR space
  function automatic logic in_subset(input logic [`PMC_SFR_AW-1:0] a);
    in_subset = (a < `PMC_SFR_AW'(`PMC_HW_SUBSET_N));
  endfunction
  logic [3:0] idx;
  assign idx = g.addr[3:0];
  // R7: system unrestricted, user gated
  // R9: firmware uses its own grant_fw register
  always_comb
  begin
    case (g.mode)
      pmc_pkg::PMC_SYS: g.allow = 1'b1;
      pmc_pkg::PMC_USER: g.allow = in_subset(g.addr) && g.grant_user[idx];
      pmc_pkg::PMC_FW: g.allow = in_subset(g.addr) && g.grant_fw[idx];
      pmc_pkg::PMC_BOOT: g.allow = 1'b1;
      pmc_pkg::PMC_TEST: g.allow = 1'b1;
      default: g.allow = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== pmc_sfr_model.sv ====
`default_nettype none
`include "pmc_consts.svh"
// SFR file standing behind the access gate
module pmc_sfr_model
(
  input wire logic clk,
  input wire logic fwd_we,
  input wire logic [`PMC_SFR_AW-1:0] fwd_addr,
  input wire logic [31:0] fwd_wdata,
  input wire logic rd_sel,
  input wire logic [`PMC_SFR_AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [2**`PMC_SFR_AW];
  logic [31:0] last = 32'h0000_0000;
  ////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (fwd_we)
      mem[fwd_addr] <= fwd_wdata;
    last <= rd_data;
  end
  // Unselected: inverse of last value, so no stale data passes
  assign rd_data = rd_sel ? mem[rd_addr] : ~last;
endmodule
`default_nettype wire

// ==== pmc_top_tb.sv ====
`default_nettype none
`include "pmc_consts.svh"
module pmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, test_disable_fuse, test_disable_burn, fw_call, sys_call, exc_req, irq_req;
  logic ret_req, ret_to_user, boot_done, app_mem_req, sfr_req, sfr_we, grant_we, grant_sel_fw;
  logic [2:0] fw_call_idx, exc_idx, mode;
  logic [4:0] sys_call_idx;
  logic [3:0] irq_idx;
  logic [`PMC_SFR_AW-1:0] sfr_addr, sfr_fwd_addr;
  logic [31:0] sfr_wdata, sfr_rdata_in, jump_addr, sfr_fwd_wdata, sfr_rdata;
  logic [`PMC_HW_SUBSET_N-1:0] grant_wdata;
  logic super_system, jump, test_disabled, app_mem_allow, sfr_fwd_we, sfr_fwd_re, sfr_denied;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  pmc_top #(.BOOT_CYCLES(4)) pmc_top_inst (.clk, .rst, .test_disable_fuse, .test_disable_burn,
    .fw_call, .fw_call_idx, .sys_call, .sys_call_idx, .exc_req, .exc_idx, .irq_req, .irq_idx,
    .ret_req, .ret_to_user, .boot_done, .app_mem_req, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata,
    .sfr_rdata_in, .grant_we, .grant_sel_fw, .grant_wdata, .mode, .super_system, .jump, .jump_addr,
    .test_disabled, .app_mem_allow, .sfr_fwd_we, .sfr_fwd_re, .sfr_fwd_addr, .sfr_fwd_wdata,
    .sfr_rdata, .sfr_denied);
  pmc_sfr_model pmc_sfr_model_inst (.clk, .fwd_we(sfr_fwd_we), .fwd_addr(sfr_fwd_addr),
    .fwd_wdata(sfr_fwd_wdata), .rd_sel(sfr_req), .rd_addr(sfr_addr), .rd_data(sfr_rdata_in));
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task do_reset(input logic fuse);
    @(posedge clk);
    rst <= 1;
    test_disable_fuse <= fuse;
    repeat (20) @(posedge clk);
    #1;
    chk("reset mode", pmc_pkg::PMC_BOOT, mode);
    chk("reset super", 1, super_system);
    rst <= 0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 20 && mode === pmc_pkg::PMC_BOOT; i++)
      @(posedge clk);
    #1;
  endtask
  // Call, event or return; ej says whether a jump is due
  task ev(input int k, input logic [4:0] idx, input logic ej, input logic [31:0] ea, input logic [2:0] em);
    @(posedge clk);
    case (k)
      0: begin fw_call <= 1; fw_call_idx <= idx[2:0]; end
      1: begin sys_call <= 1; sys_call_idx <= idx; end
      2: begin exc_req <= 1; exc_idx <= idx[2:0]; end
      3: begin irq_req <= 1; irq_idx <= idx[3:0]; end
      default: ret_req <= 1;
    endcase
    @(posedge clk);
    {fw_call, sys_call, exc_req, irq_req, ret_req} <= 5'h0;
    #1;
    if (k < 4)
      chk("jump", ej, jump);
    if (ej)
      chk("jump_addr", ea, jump_addr);
    @(posedge clk);
    #1;
    chk("mode", em, mode);
  endtask
  task sfr(input logic we, input logic [7:0] a, input logic [31:0] d, input logic ok);
    @(posedge clk);
    {sfr_req, sfr_we, sfr_addr, sfr_wdata} <= {1'b1, we, a, d};
    @(posedge clk);
    {sfr_req, sfr_we} <= 2'b00;
    #1;
    chk("sfr_denied", !ok, sfr_denied);
    chk("sfr_fwd_re", !we && ok, sfr_fwd_re);
    if (ok)
      chk("sfr_fwd_addr", a, sfr_fwd_addr);
    if (we)
      chk("sfr_fwd_we", ok, sfr_fwd_we);
    else
      chk("sfr_rdata", ok ? d : 32'h0000_0000, sfr_rdata);
  endtask
  task grant(input logic fw, input logic [15:0] g);
    @(posedge clk);
    {grant_we, grant_sel_fw, grant_wdata} <= {1'b1, fw, g};
    @(posedge clk);
    grant_we <= 0;
  endtask
  ////////////////////////////////////////////////////////////
  task t_test_mode();
    do_reset(0);
    chk("mode", pmc_pkg::PMC_TEST, mode);
    chk("app_mem_allow", 1, app_mem_allow);
    ev(0, 5'h02, 0, 0, pmc_pkg::PMC_TEST);
    @(posedge clk);
    test_disable_burn <= 1;
    @(posedge clk);
    test_disable_burn <= 0;
    @(posedge clk);
    #1;
    chk("test_disabled", 1, test_disabled);
  endtask
  task t_disable();
    // Fuse level held high through the reset sets the disable again
    do_reset(1);
    chk("mode", pmc_pkg::PMC_SYS, mode);
    chk("test_disabled", 1, test_disabled);
    chk("super", 0, super_system);
  endtask
  task t_vectors();
    ev(1, 5'h03, 0, 0, pmc_pkg::PMC_SYS);
    ret_to_user <= 1;
    ev(4, 5'h00, 0, 0, pmc_pkg::PMC_USER);
    ev(1, 5'h1f, 1, 32'h0000_02f8, pmc_pkg::PMC_SYS);
    ev(4, 5'h00, 0, 0, pmc_pkg::PMC_USER);
    ev(0, 5'h07, 1, 32'h0000_0138, pmc_pkg::PMC_FW);
    chk("super", 1, super_system);
    chk("app_mem_allow", 0, app_mem_allow);
    ret_to_user <= 0;
    ev(4, 5'h00, 0, 0, pmc_pkg::PMC_SYS);
    ev(0, 5'h00, 1, 32'h0000_0100, pmc_pkg::PMC_FW);
    ev(2, 5'h05, 1, 32'h0000_0428, pmc_pkg::PMC_SYS);
    ev(3, 5'h0f, 1, 32'h0000_0578, pmc_pkg::PMC_SYS);
  endtask
  task t_sfr();
    sfr(1, 8'h03, 32'h1234_abcd, 1);
    sfr(1, 8'h05, 32'h5a5a_0f0f, 1);
    sfr(0, 8'h03, 32'h1234_abcd, 1);
    ret_to_user <= 1;
    ev(4, 5'h00, 0, 0, pmc_pkg::PMC_USER);
    sfr(1, 8'h03, 32'hdead_0001, 0);
    sfr(0, 8'h03, 32'h1234_abcd, 0);
    // Grant from user mode must be ignored
    grant(0, 16'h0008);
    sfr(0, 8'h03, 32'h1234_abcd, 0);
    ev(1, 5'h00, 1, 32'h0000_0200, pmc_pkg::PMC_SYS);
    grant(0, 16'h0008);
    grant(1, 16'h0020);
    ev(4, 5'h00, 0, 0, pmc_pkg::PMC_USER);
    sfr(0, 8'h03, 32'h1234_abcd, 1);
    sfr(0, 8'h05, 32'h5a5a_0f0f, 0);
    ev(0, 5'h01, 1, 32'h0000_0108, pmc_pkg::PMC_FW);
    sfr(0, 8'h05, 32'h5a5a_0f0f, 1);
    sfr(0, 8'h03, 32'h1234_abcd, 0);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    {rst, test_disable_fuse, test_disable_burn, fw_call, sys_call, exc_req, irq_req} = 7'h40;
    {ret_req, ret_to_user, sfr_req, sfr_we, grant_we, grant_sel_fw} = 6'h00;
    {fw_call_idx, exc_idx, sys_call_idx, irq_idx} = 15'h0000;
    {sfr_addr, sfr_wdata, grant_wdata} = 56'h0;
    boot_done = 1;
    app_mem_req = 1;
    t_test_mode();
    t_disable();
    t_vectors();
    t_sfr();
    results();
  end
endmodule
`default_nettype wire
